// File: core/atdc_pkg.sv
package atdc_pkg;

  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] REG_AFC    = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_TUNE   = 8'h08;
  localparam logic [7:0] REG_DAC    = 8'h0C;
  localparam logic [7:0] REG_CLKDIV = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // correction loop settings
  typedef struct packed {
    logic [7:0]  rangeLimit;   // corr_range_limit, steps of 500 Hz
    logic [3:0]  rsvd;
    logic [3:0]  integralGain;
    logic [3:0]  proportionalGain;
    logic [11:0] scale;        // freq_corr_scale
  } atdc_afc_reg_t;

  // loose control bits
  typedef struct packed {
    logic [28:0] rsvd;
    logic        corrSelect;   // 1: correlator output into the dac
    logic        lockThreshold;
    logic        rfHalve;      // rf_halve_option
  } atdc_cfg_reg_t;

  // demodulator tuning, gated by the test-mode field
  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0]  detectorPeak;
    logic [3:0]  detectorLeak;
    logic [3:0]  pulseStretch;
    logic [3:0]  testMode;     // bits 7:4
    logic [3:0]  rsvdLow;
  } atdc_tune_reg_t;

  // test dac: offset removal and gain (gain is unsigned, 4 fraction bits)
  typedef struct packed {
    logic [7:0]  rsvd;
    logic [7:0]  gain;
    logic [15:0] offset;
  } atdc_dac_reg_t;

  // clock dividers: demod from clk, recovery from demod
  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0]  recoveryDiv;
    logic [7:0]  demodDiv;
  } atdc_clk_reg_t;

  localparam atdc_afc_reg_t AFC_RESET = 32'h0A00_B4E6;
  localparam atdc_cfg_reg_t CFG_RESET = 32'h0000_0000;
  localparam atdc_tune_reg_t TUNE_RESET = 32'h0000_0000;
  localparam atdc_dac_reg_t DAC_RESET = 32'h0010_0000;
  localparam atdc_clk_reg_t CLK_RESET = 32'h0000_2003;

  localparam logic [3:0]  TEST_MODE_TUNE = 4'h9;
  localparam logic [23:0] RANGE_STEP_HZ  = 24'h00_01F4;
  localparam int          SCALE_SHIFT    = 12;
  localparam int          GAIN_FRAC      = 4;
  localparam logic signed [19:0] DAC_POS_FS = 20'h0_7FFF;
  localparam logic signed [19:0] DAC_NEG_FS = 20'hF_8000;

  typedef enum logic {SRC_LINEAR, SRC_CORRELATOR} atdc_src_t;

endpackage

// File: core/atdc_fifo.sv
`timescale 1ns/1ps
module atdc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      wrPtr_nxt;
  logic [AW:0]      rdPtr_r;
  logic [AW:0]      rdPtr_nxt;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  always_comb
  begin
    level     = wrPtr_r - rdPtr_r;
    inReady   = (level != (AW+1)'(DEPTH));
    outValid  = (level != '0);
    push      = inValid && inReady;
    pop       = outValid && outReady;
    wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
    outData   = mem_r[rdPtr_r[AW-1:0]];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  // storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wrPtr_r[AW-1:0]] <= inData;
  end
endmodule

// File: core/atdc_control.sv
// Overview of operation
// - correction is clamped to range limit times 500 Hz
// - rf halve option halves the range; host doubles the limit
// - lock threshold freezes envelope threshold and correction/gain loops, and the slicer only with the linear source selected
// - stretch, leak and peak tuning act only when test mode is 0x9
// - 16-bit filter output drives a second-order error-feedback sigma-delta
// - one-bit dac stream replaces the sync-detect indication on its pin
// - filters run on demod ticks, modulator on recovery ticks
// - recovery rate at or above demod rate stops clock recovery
// - writing the dac register enables the dac; source selects linear/correlator
// - dac path removes a programmed offset and applies a programmed gain
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module atdc_control #(
  parameter int SAMPLE_W   = 16,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [31:0]                regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic [31:0]                     regRdata,
  input  wire logic signed [SAMPLE_W-1:0] linearSample,
  input  wire logic signed [SAMPLE_W-1:0] corrSample,
  input  wire logic                       sampleValid,
  output logic                            sampleReady,
  input  wire logic signed [15:0]         freqError,
  input  wire logic                       freqErrorValid,
  output logic signed [23:0]              freqCorrection,
  input  wire logic [7:0]                 envelopeLevel,
  output logic [7:0]                      envThreshold,
  output logic                            slicerHold,
  output logic                            loopHold,
  output logic [3:0]                      pulseStretch,
  output logic [3:0]                      detectorLeak,
  output logic [3:0]                      detectorPeak,
  output logic                            demodTick,
  output logic                            recoveryTick,
  output logic                            cdrRunning,
  input  wire logic                       syncDetect,
  output logic                            syncPin
);
  atdc_pkg::atdc_afc_reg_t  afcReg_r, afcReg_nxt;
  atdc_pkg::atdc_cfg_reg_t  cfgReg_r, cfgReg_nxt;
  atdc_pkg::atdc_tune_reg_t tuneReg_r, tuneReg_nxt;
  atdc_pkg::atdc_dac_reg_t  dacReg_r, dacReg_nxt;
  atdc_pkg::atdc_clk_reg_t  clkReg_r, clkReg_nxt;
  logic        dacEnable_r, dacEnable_nxt;
  logic [31:0] regRdata_nxt;
  logic [7:0]  demodCnt_r, demodCnt_nxt;
  logic [7:0]  recCnt_r, recCnt_nxt;
  logic        cdrRunning_r, cdrRunning_nxt;
  logic signed [23:0] integ_r, integ_nxt;
  logic signed [23:0] corr_r, corr_nxt;
  logic [7:0]  envThr_r, envThr_nxt;
  logic [3:0]  stretch_r, stretch_nxt, leak_r, leak_nxt, peak_r, peak_nxt;
  logic signed [SAMPLE_W-1:0] held_r, held_nxt;
  logic signed [19:0] err1_r, err1_nxt, err2_r, err2_nxt;
  logic        modBit_r, modBit_nxt;
  logic        syncPin_r, syncPin_nxt;
  logic [23:0] corrLimit;
  logic [23:0] rangeHz;
  logic signed [28:0] errProd;
  logic signed [23:0] errScaled;
  logic signed [SAMPLE_W-1:0] srcSample, dacIn, fifoOut;
  logic        fifoInReady, fifoOutValid, fifoPush, fifoPop;
  logic [$clog2(FIFO_DEPTH):0] fifoLevel;
  logic signed [19:0] modSum;
  logic        fastRecovery;

  // clamp a wide value into a symmetric window
  function automatic logic signed [23:0] sat24(input logic signed [24:0] v,
                                               input logic [23:0] lim);
    logic signed [24:0] hi;
    hi = $signed({1'b0, lim});
    if (v > hi)
      sat24 = 24'(hi);
    else if (v < -hi)
      sat24 = 24'(-hi);
    else
      sat24 = 24'(v);
  endfunction

  // clamp to the sample width
  function automatic logic signed [SAMPLE_W-1:0] satSample(input logic signed [31:0] v);
    logic signed [31:0] hi;
    hi = 32'((2 ** (SAMPLE_W - 1)) - 1);
    if (v > hi)
      satSample = SAMPLE_W'(hi);
    else if (v < -hi - 1)
      satSample = SAMPLE_W'(-hi - 1);
    else
      satSample = SAMPLE_W'(v);
  endfunction

  // register writes; reserved bits are forced to zero so they read back zero
  always_comb
  begin
    afcReg_nxt    = afcReg_r;
    cfgReg_nxt    = cfgReg_r;
    tuneReg_nxt   = tuneReg_r;
    dacReg_nxt    = dacReg_r;
    clkReg_nxt    = clkReg_r;
    dacEnable_nxt = dacEnable_r;
    if (regWrite)
    begin
      unique case (regAddr)
        atdc_pkg::REG_AFC:
        begin
          afcReg_nxt      = regWdata;
          afcReg_nxt.rsvd = '0;
        end
        atdc_pkg::REG_CFG:
        begin
          cfgReg_nxt      = regWdata;
          cfgReg_nxt.rsvd = '0;
        end
        atdc_pkg::REG_TUNE:
        begin
          tuneReg_nxt         = regWdata;
          tuneReg_nxt.rsvd    = '0;
          tuneReg_nxt.rsvdLow = '0;
        end
        atdc_pkg::REG_DAC:
        begin
          dacReg_nxt      = regWdata;
          dacReg_nxt.rsvd = '0;
          dacEnable_nxt   = 1'b1;
        end
        atdc_pkg::REG_CLKDIV:
        begin
          clkReg_nxt      = regWdata;
          clkReg_nxt.rsvd = '0;
        end
        default: ;
      endcase
    end
    // read data stand in the cycle after the strobe only
    regRdata_nxt = '0;
    if (regRead)
    begin
      unique case (regAddr)
        atdc_pkg::REG_AFC:    regRdata_nxt = afcReg_r;
        atdc_pkg::REG_CFG:    regRdata_nxt = cfgReg_r;
        atdc_pkg::REG_TUNE:   regRdata_nxt = tuneReg_r;
        atdc_pkg::REG_DAC:    regRdata_nxt = dacReg_r;
        atdc_pkg::REG_CLKDIV: regRdata_nxt = clkReg_r;
        atdc_pkg::REG_STATUS:
          regRdata_nxt = {corr_r, 1'b0, 4'(fifoLevel), cdrRunning_r, modBit_r, dacEnable_r};
        default:              regRdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      afcReg_r    <= atdc_pkg::AFC_RESET;
      cfgReg_r    <= atdc_pkg::CFG_RESET;
      tuneReg_r   <= atdc_pkg::TUNE_RESET;
      dacReg_r    <= atdc_pkg::DAC_RESET;
      clkReg_r    <= atdc_pkg::CLK_RESET;
      dacEnable_r <= 1'b0;
      regRdata    <= '0;
    end
    else
    begin
      afcReg_r    <= afcReg_nxt;
      cfgReg_r    <= cfgReg_nxt;
      tuneReg_r   <= tuneReg_nxt;
      dacReg_r    <= dacReg_nxt;
      clkReg_r    <= clkReg_nxt;
      dacEnable_r <= dacEnable_nxt;
      regRdata    <= regRdata_nxt;
    end
  end

  // tick dividers; divider values 0 and 1 both mean every cycle
  always_comb
  begin
    demodTick      = (demodCnt_r == 8'h00);
    demodCnt_nxt   = demodTick ? clkReg_r.demodDiv - 8'h01 : demodCnt_r - 8'h01;
    if (clkReg_r.demodDiv == 8'h00)
      demodCnt_nxt = 8'h00;
    fastRecovery   = (clkReg_r.recoveryDiv <= 8'h01);
    // recovery at or above demod rate runs free on clk; recovery logic stops
    recoveryTick   = fastRecovery ? 1'b1 : (demodTick && recCnt_r == 8'h00);
    recCnt_nxt     = recCnt_r;
    if (demodTick)
      recCnt_nxt   = (recCnt_r == 8'h00) ? clkReg_r.recoveryDiv - 8'h01 : recCnt_r - 8'h01;
    if (fastRecovery)
      recCnt_nxt   = 8'h00;
    cdrRunning_nxt = !fastRecovery;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      demodCnt_r   <= '0;
      recCnt_r     <= '0;
      cdrRunning_r <= 1'b0;
    end
    else
    begin
      demodCnt_r   <= demodCnt_nxt;
      recCnt_r     <= recCnt_nxt;
      cdrRunning_r <= cdrRunning_nxt;
    end
  end

  // correction loop: scaled error, integral and proportional paths, clamp
  always_comb
  begin
    rangeHz   = 24'(afcReg_r.rangeLimit * atdc_pkg::RANGE_STEP_HZ);
    corrLimit = cfgReg_r.rfHalve ? (rangeHz >> 1) : rangeHz;
    errProd   = freqError * $signed({1'b0, afcReg_r.scale});
    errScaled = 24'(errProd >>> atdc_pkg::SCALE_SHIFT);
    integ_nxt = integ_r;
    corr_nxt  = sat24(25'(integ_r), corrLimit);
    if (freqErrorValid && demodTick && !cfgReg_r.lockThreshold)
    begin
      integ_nxt = sat24(25'(integ_r) + 25'(errScaled >>> afcReg_r.integralGain), corrLimit);
      corr_nxt  = sat24(25'(integ_nxt) + 25'(errScaled >>> afcReg_r.proportionalGain),
                        corrLimit);
    end
    else if (cfgReg_r.lockThreshold)
      corr_nxt  = corr_r;
    // envelope threshold tracks the detector until locked
    envThr_nxt  = cfgReg_r.lockThreshold ? envThr_r : envelopeLevel;
    // tuning fields pass only under the tuning test mode
    if (tuneReg_r.testMode == atdc_pkg::TEST_MODE_TUNE)
    begin
      stretch_nxt = tuneReg_r.pulseStretch;
      leak_nxt    = tuneReg_r.detectorLeak;
      peak_nxt    = tuneReg_r.detectorPeak;
    end
    else
    begin
      stretch_nxt = '0;
      leak_nxt    = '0;
      peak_nxt    = '0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      integ_r   <= '0;
      corr_r    <= '0;
      envThr_r  <= '0;
      stretch_r <= '0;
      leak_r    <= '0;
      peak_r    <= '0;
    end
    else
    begin
      integ_r   <= integ_nxt;
      corr_r    <= corr_nxt;
      envThr_r  <= envThr_nxt;
      stretch_r <= stretch_nxt;
      leak_r    <= leak_nxt;
      peak_r    <= peak_nxt;
    end
  end

  assign freqCorrection = corr_r;
  assign envThreshold   = envThr_r;
  assign loopHold       = cfgReg_r.lockThreshold;
  assign slicerHold     = cfgReg_r.lockThreshold &&
                          (atdc_pkg::atdc_src_t'(cfgReg_r.corrSelect) == atdc_pkg::SRC_LINEAR);
  assign pulseStretch   = stretch_r;
  assign detectorLeak   = leak_r;
  assign detectorPeak   = peak_r;

  // input side on demod ticks: select, remove offset, apply gain
  always_comb
  begin
    srcSample = cfgReg_r.corrSelect ? corrSample : linearSample;
    dacIn     = satSample(32'(((32'(srcSample) - 32'($signed(dacReg_r.offset)))
                * $signed({24'h00_0000, dacReg_r.gain})) >>> atdc_pkg::GAIN_FRAC));
    fifoPush  = sampleValid && demodTick && dacEnable_r;
    // with the dac off, samples are taken and dropped
    sampleReady = demodTick && (!dacEnable_r || fifoInReady);
  end

  // four-word buffer absorbs the rate gap between the two tick domains
  atdc_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .inData   (dacIn),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .level    (fifoLevel)
  );

  // second-order error-feedback modulator on recovery ticks
  always_comb
  begin
    fifoPop    = recoveryTick && dacEnable_r;
    held_nxt   = (fifoPop && fifoOutValid) ? fifoOut : held_r;
    modSum     = 20'(held_r) - (err1_r <<< 1) + err2_r;
    modBit_nxt = modBit_r;
    err1_nxt   = err1_r;
    err2_nxt   = err2_r;
    if (fifoPop)
    begin
      modBit_nxt = !modSum[19];
      err1_nxt   = (modSum[19] ? atdc_pkg::DAC_NEG_FS : atdc_pkg::DAC_POS_FS) - modSum;
      err2_nxt   = err1_r;
    end
    syncPin_nxt  = dacEnable_r ? modBit_r : syncDetect;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      held_r    <= '0;
      err1_r    <= '0;
      err2_r    <= '0;
      modBit_r  <= 1'b0;
      syncPin_r <= 1'b0;
    end
    else
    begin
      held_r    <= held_nxt;
      err1_r    <= err1_nxt;
      err2_r    <= err2_nxt;
      modBit_r  <= modBit_nxt;
      syncPin_r <= syncPin_nxt;
    end
  end

  assign syncPin    = syncPin_r;
  assign cdrRunning = cdrRunning_r;

  a_range_clamp: assert property (@(posedge clk) disable iff (reset)
    ($signed(corr_r) <= $signed({1'b0, corrLimit})) || $changed(corrLimit))
    else $error("correction beyond range limit");
  a_halve_range: assert property (@(posedge clk) disable iff (reset)
    cfgReg_r.rfHalve |-> corrLimit == 24'((afcReg_r.rangeLimit * 500) / 2))
    else $error("range not halved");
  a_lock_freeze: assert property (@(posedge clk) disable iff (reset)
    cfgReg_r.lockThreshold ##1 cfgReg_r.lockThreshold |-> $stable(freqCorrection)
      && $stable(envThreshold))
    else $error("loops moved while locked");
  a_slicer_hold: assert property (@(posedge clk) disable iff (reset)
    slicerHold |-> loopHold && !cfgReg_r.corrSelect)
    else $error("slicer hold outside linear lock");
  a_tune_gate: assert property (@(posedge clk) disable iff (reset)
    tuneReg_r.testMode != 4'h9 |=> pulseStretch == 4'h0 && detectorLeak == 4'h0
      && detectorPeak == 4'h0)
    else $error("tuning active outside test mode");
  a_pin_source: assert property (@(posedge clk) disable iff (reset)
    ##1 syncPin == ($past(dacEnable_r) ? $past(modBit_r) : $past(syncDetect)))
    else $error("wrong source on sync pin");
  a_mod_recovery: assert property (@(posedge clk) disable iff (reset)
    !recoveryTick |=> $stable(modBit_r) && $stable(err1_r))
    else $error("modulator stepped off recovery tick");
  a_cdr_stop: assert property (@(posedge clk) disable iff (reset)
    clkReg_r.recoveryDiv <= 8'h01 |=> !cdrRunning)
    else $error("recovery still running at fast rate");
  a_dac_enable: assert property (@(posedge clk) disable iff (reset)
    regWrite && regAddr == 8'h0C |=> dacEnable_r ##1 dacEnable_r)
    else $error("dac write did not enable");
endmodule

// File: sim/atdc_host.sv
`timescale 1ns/1ps
// host controller model driving the plain register port
module atdc_host (
  input  wire logic        clk,
  output logic [7:0]       regAddr,
  output logic [31:0]      regWdata,
  output logic             regWrite,
  output logic             regRead,
  input  wire logic [31:0] regRdata
);
  // idle bus from time zero
  initial
  begin
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // one-cycle write strobe; the extra edge keeps strobes from being assigned twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so take them mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask

  // correction setup: scale from crystal, recommended gains, range doubled when halving
  task automatic afcSetup(input longint xtalHz, input logic halve, input logic [7:0] range);
    longint scale;
    scale = ((longint'(1) << 24) * 500 + xtalHz / 2) / xtalHz;
    wr(atdc_pkg::REG_AFC, {(halve ? {range[6:0], 1'b0} : range), 4'h0, 4'd11, 4'd4,
       scale[11:0]});
  endtask
endmodule

// File: sim/atdc_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module atdc_control_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr, envelopeLevel = 8'h00, envThreshold;
  logic [31:0] regWdata, regRdata;
  logic regWrite, regRead, sampleReady, slicerHold, loopHold;
  logic sampleValid = 1'b0, freqErrorValid = 1'b0, syncDetect = 1'b0;
  logic signed [15:0] linearSample = '0, corrSample = '0, freqError = '0;
  logic signed [23:0] freqCorrection;
  logic [3:0] pulseStretch, detectorLeak, detectorPeak;
  logic demodTick, recoveryTick, cdrRunning, syncPin;
  int n_errors = 0;
  int num_checks = 0;

  // 250 MHz
  always #2 clk = ~clk;

  atdc_host host (.clk, .regAddr, .regWdata, .regWrite, .regRead, .regRdata);

  atdc_control #(.SAMPLE_W(16), .FIFO_DEPTH(4)) dut (
    .clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .linearSample, .corrSample, .sampleValid, .sampleReady, .freqError,
    .freqErrorValid, .freqCorrection, .envelopeLevel, .envThreshold, .slicerHold,
    .loopHold, .pulseStretch, .detectorLeak, .detectorPeak, .demodTick,
    .recoveryTick, .cdrRunning, .syncDetect, .syncPin
  );

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bench model of the offset, gain and saturation stage
  function automatic int dacModel(input int s, input int off, input int g);
    int v;
    v = ((s - off) * g) >>> 4;
    return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
  endfunction

  // loop converges slowly, so poll under a bound
  task automatic waitCorr(input logic signed [23:0] exp);
    int i;
    for (i = 0; i < 4000 && freqCorrection !== exp; i++)
      @(negedge clk);
    `CHK(freqCorrection, exp, "correction limit")
    // a loop that never settles goes straight to the closing report
    if (freqCorrection !== exp)
      results();
  endtask

  // one sample handed over when valid meets ready at a rising edge
  task automatic push(input logic signed [15:0] a, input logic signed [15:0] b);
    int i;
    @(posedge clk);
    linearSample <= a;
    corrSample <= b;
    sampleValid <= 1'b1;
    @(negedge clk);
    for (i = 0; i < 300 && sampleReady !== 1'b1; i++)
      @(negedge clk);
    if (i == 300)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t sample never accepted", $time);
      results();
    end
    @(posedge clk);
    sampleValid <= 1'b0;
  endtask

  initial
  begin
    int i, j, ones, ticksR, u, off, g, a, b, e;
    logic [31:0] d;
    logic prv, nv;
    logic [3:0] m;
    u = $urandom(32'h40a7);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // reset values and an unmapped address
    host.rd(atdc_pkg::REG_AFC, d);
    `CHK(d, 32'h0A00_B4E6, "afc reset")
    host.rd(atdc_pkg::REG_DAC, d);
    `CHK(d, 32'h0010_0000, "dac reset")
    host.rd(atdc_pkg::REG_CLKDIV, d);
    `CHK(d, 32'h0000_2003, "clkdiv reset")
    host.rd(8'h18, d);
    `CHK(d, 32'h0000_0000, "unmapped read")
    $display("test reset done");
    // sync indication passes one cycle late while the dac is off
    prv = 1'b0;
    for (i = 0; i < 12; i++)
    begin
      nv = 1'($urandom_range(0, 1));
      @(posedge clk);
      syncDetect <= nv;
      @(negedge clk);
      if (i > 0)
        `CHK(syncPin, prv, "sync pass")
      prv = nv;
    end
    $display("test sync done");
    // tuning fields only with test mode nine
    for (i = 0; i < 4; i++)
    begin
      m = (i == 0) ? 4'h9 : 4'($urandom_range(0, 8));
      d = {12'h000, 12'($urandom), m, 4'h0};
      host.wr(atdc_pkg::REG_TUNE, d);
      ticks(2);
      `CHK({detectorPeak, detectorLeak, pulseStretch}, (m == 4'h9) ? d[19:8] : 12'h000, "tune")
    end
    $display("test tuning done");
    // correction clamp, halving, lock freeze
    host.wr(atdc_pkg::REG_CLKDIV, 32'h0000_0101);
    host.afcSetup(64'd19_200_000, 1'b0, 8'd2);
    @(posedge clk);
    freqError <= 16'sh7FFF;
    freqErrorValid <= 1'b1;
    waitCorr(24'sd1000);
    host.wr(atdc_pkg::REG_CFG, 32'h0000_0001);
    waitCorr(24'sd500);
    host.afcSetup(64'd19_200_000, 1'b1, 8'd2);
    waitCorr(24'sd1000);
    host.wr(atdc_pkg::REG_CFG, 32'h0000_0003);
    @(posedge clk);
    freqError <= -16'sh7FFF;
    envelopeLevel <= 8'h5A;
    ticks(50);
    `CHK(freqCorrection, 24'sd1000, "corr frozen")
    `CHK({loopHold, slicerHold, envThreshold}, 10'h300, "lock linear")
    host.wr(atdc_pkg::REG_CFG, 32'h0000_0007);
    ticks(2);
    `CHK({loopHold, slicerHold}, 2'b10, "lock correlator")
    host.wr(atdc_pkg::REG_CFG, 32'h0000_0005);
    ticks(2);
    `CHK({loopHold, slicerHold, envThreshold}, 10'h05A, "unlocked")
    waitCorr(-24'sd1000);
    @(posedge clk);
    freqErrorValid <= 1'b0;
    $display("test correction done");
    // demod ticks every 2 cycles, recovery every 4 demod ticks
    host.wr(atdc_pkg::REG_CLKDIV, 32'h0000_0402);
    ticks(20);
    ones = 0;
    ticksR = 0;
    for (i = 0; i < 64; i++)
    begin
      @(negedge clk);
      ones += int'(demodTick === 1'b1);
      ticksR += int'(recoveryTick === 1'b1);
    end
    `CHK(ones, 32, "demod rate")
    `CHK(ticksR, 8, "recovery rate")
    `CHK(cdrRunning, 1'b1, "cdr on")
    host.wr(atdc_pkg::REG_CLKDIV, 32'h0000_0101);
    ticks(2);
    `CHK({cdrRunning, recoveryTick}, 2'b01, "cdr off")
    $display("test clocks done");
    // slow recovery lets the buffer fill until it refuses
    host.wr(atdc_pkg::REG_CLKDIV, 32'h0000_FF01);
    host.rd(atdc_pkg::REG_STATUS, d);
    `CHK(d[0], 1'b0, "dac off")
    host.wr(atdc_pkg::REG_DAC, 32'h0010_0000);
    host.rd(atdc_pkg::REG_STATUS, d);
    `CHK(d[0], 1'b1, "dac on")
    @(posedge clk);
    linearSample <= 16'sh1000;
    sampleValid <= 1'b1;
    for (i = 0; i < 40 && sampleReady !== 1'b0; i++)
      @(negedge clk);
    `CHK(sampleReady, 1'b0, "fifo full")
    if (sampleReady !== 1'b0)
      results();
    host.rd(atdc_pkg::REG_STATUS, d);
    `CHK(d[6:3], 4'd4, "fifo level")
    @(posedge clk);
    sampleValid <= 1'b0;
    host.wr(atdc_pkg::REG_CLKDIV, 32'h0000_0101);
    // bit density of the one-bit stream tracks the scaled sample
    for (i = 0; i < 4; i++)
    begin
      host.wr(atdc_pkg::REG_CFG, {29'h0, i[0], 2'b00});
      // inputs kept well inside the one-bit modulator's stable input range
      a = $urandom_range(0, 16384) - 8192;
      b = $urandom_range(0, 16384) - 8192;
      off = $urandom_range(0, 2047) - 1024;
      g = $urandom_range(16, 24);
      host.wr(atdc_pkg::REG_DAC, {8'h00, 8'(g), 16'(off)});
      push(16'(a), 16'(b));
      u = dacModel(i[0] ? b : a, off, g);
      e = 1024 * (u + 32768) / 65536;
      ticks(40);
      ones = 0;
      for (j = 0; j < 1024; j++)
      begin
        @(negedge clk);
        ones += int'(syncPin === 1'b1);
      end
      `CHK(ones > e - 8 && ones < e + 8, 1'b1, "dac density")
    end
    $display("test dac done");
    results();
  end
endmodule
